/* File: verilog/sgc_chain.v */
// One channel of polyphase shaping filter, gain profile and output gain control.
`timescale 1ns/10ps
`include "sgc_consts.vh"

// Summary of operation
// - Phase k output sums coefficient k+16j times sample n-j over the span.
// - Set-select picks second coefficient set, starting at address 8 (128 for 16 phases).
// - Coefficients accepted as 16-bit two's complement or 24-bit float.
// - Float coefficient is 20-bit mantissa scaled by two to minus exponent for exponents 0 to 13.
// - Format resets to two's complement; bit 12 of word 0x17 selects float.
// - Filter gain is coefficient sum over number of phases.
// - Filter output saturates at plus or minus full scale, never wraps.
// - Profile and gain stages scale I and Q identically.
// - Profile memory is 128 by 12 at indirect addresses 0x000 to 0x07f.
// - Profile word multiplies each filter output at the coarse phase rate.
// - Bit 15 of word 0xd enables profile; enabling resets pointer to zero.
// - Key rising edge steps pointer up at coarse rate to profile length.
// - Key falling edge steps pointer down to zero, mirroring ramp up.
// - Bit 8 of word 0x0b bypasses key alignment and feeds key directly.
// - Bit 7 of word 0x0b removes two alignment stages from key path.
// - Bit 14 of word 0x0c freezes gain; profile writes are accepted with or without it.
// - Profile words are unsigned, 0x800 unity, LSB two to minus eleven.
// - Gain control multiplies then shifts to set final gain.
// - Bits 11:0 of word 0xa scale by value over 4096.
// - Bits 14:12 of word 0xa divide by 4096,256,32,16,8,4,2,1.
// - Word 0xd bits 1:0 select 4/8/16 phases; bits 7:4 span minus one.
// - Bit 8 of word 0xd selects the active coefficient set.
module sgc_chain
#(
	parameter ALIGN_DEPTH = `SGC_ALIGN_DEPTH
)
(
	input  wire               mclk,
	input  wire               rst,
	input  wire               ce,
	input  wire               reg_wr,
	input  wire               mem_wr,
	input  wire               reg_rd,
	input  wire [7:0]         reg_addr,
	input  wire [9:0]         mem_addr,
	input  wire [23:0]        wdata,
	output reg  [15:0]        rdata,
	input  wire               sample_tick,
	input  wire               coarse_tick,
	input  wire signed [15:0] i_in,
	input  wire signed [15:0] q_in,
	input  wire               burst_key_in,
	output reg  signed [17:0] i_out,
	output reg  signed [17:0] q_out,
	output reg                out_valid,
	output wire [6:0]         profile_pointer
);
	// ------------------------------------------------------------
	// Control words
	// ------------------------------------------------------------
	reg [15:0] output_gain_word;
	reg [15:0] profile_length_latency;
	reg [15:0] profile_hold_word;
	reg [15:0] shaper_config_word;
	reg [15:0] coef_format_word;

	always @(posedge mclk)
	begin
		if (rst)
		begin
			output_gain_word       <= `SGC_RST_WORD;
			profile_length_latency <= `SGC_RST_WORD;
			profile_hold_word      <= `SGC_RST_WORD;
			shaper_config_word     <= `SGC_RST_WORD;
			coef_format_word       <= `SGC_RST_WORD;
		end
		else if (ce && reg_wr)
		begin
			case (reg_addr)
				`SGC_OFS_GAIN: output_gain_word       <= wdata[15:0];
				`SGC_OFS_PLEN: profile_length_latency <= wdata[15:0];
				`SGC_OFS_HOLD: profile_hold_word      <= wdata[15:0];
				`SGC_OFS_CFG:  shaper_config_word     <= wdata[15:0];
				`SGC_OFS_FMT:  coef_format_word       <= wdata[15:0];
				default: ;
			endcase
		end
	end

	always @(posedge mclk)
	begin
		if (rst)
			rdata <= 16'h0000;
		else if (ce && reg_rd)
		begin
			case (reg_addr)
				`SGC_OFS_GAIN: rdata <= output_gain_word;
				`SGC_OFS_PLEN: rdata <= profile_length_latency;
				`SGC_OFS_HOLD: rdata <= profile_hold_word;
				`SGC_OFS_CFG:  rdata <= shaper_config_word;
				`SGC_OFS_FMT:  rdata <= coef_format_word;
				default:       rdata <= {9'h000, profile_pointer};
			endcase
		end
	end

	wire       float_fmt = coef_format_word[`SGC_BIT_FLOAT];
	wire       prof_en   = shaper_config_word[`SGC_BIT_PROF_EN];
	wire       set_sel   = shaper_config_word[`SGC_BIT_SET_SEL];
	wire [1:0] ip_code   = shaper_config_word[1:0];
	wire [3:0] span_m1   = shaper_config_word[7:4];
	wire       hold      = profile_hold_word[`SGC_BIT_HOLD];

	// ------------------------------------------------------------
	// Coefficient and profile memories
	// ------------------------------------------------------------
	reg signed [17:0] coef_mem [0:255];
	reg        [11:0] prof_mem [0:127];
	wire       [7:0]  coef_waddr = mem_addr[7:0];
	reg signed [17:0] coef_conv;
	reg signed [35:0] mant_ext;

	always @*
	begin
		mant_ext = {{16{wdata[23]}}, wdata[23:4]} <<< 16;
		mant_ext = mant_ext >>> (wdata[3:0] + 5'd18);
		if (float_fmt)
			coef_conv = mant_ext[17:0];
		else
			coef_conv = {wdata[15:0], 2'b00};
	end

	always @(posedge mclk)
	begin
		if (ce && mem_wr && mem_addr[9:8] == 2'b01)
			coef_mem[coef_waddr] <= coef_conv;
		if (ce && mem_wr && mem_addr <= `SGC_PROF_MEM_TOP)
			prof_mem[mem_addr[6:0]] <= wdata[11:0];
	end

	// ------------------------------------------------------------
	// Polyphase shaping filter (I and Q share addressing)
	// ------------------------------------------------------------
	reg signed [15:0] i_hist [0:15];
	reg signed [15:0] q_hist [0:15];
	reg        [3:0]  phase;
	reg        [3:0]  tap;
	reg               busy;
	reg signed [39:0] acc_i;
	reg signed [39:0] acc_q;
	reg               fir_done;
	reg [3:0]         phase_last;
	reg [7:0]         set_base;
	wire [7:0]        caddr = set_base + {4'h0, phase} + {tap, 4'h0};
	integer           h;

	always @*
	begin
		case (ip_code)
			2'b00:   phase_last = 4'h3;
			2'b01:   phase_last = 4'h7;
			default: phase_last = 4'hf;
		endcase
		if (!set_sel)
			set_base = 8'h00;
		else if (ip_code[1])
			set_base = `SGC_SET2_LARGE;
		else
			set_base = `SGC_SET2_SMALL;
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			phase    <= 4'h0;
			tap      <= 4'h0;
			busy     <= 1'b0;
			acc_i    <= 40'h0;
			acc_q    <= 40'h0;
			fir_done <= 1'b0;
			for (h = 0; h < 16; h = h + 1)
			begin
				i_hist[h] <= 16'h0000;
				q_hist[h] <= 16'h0000;
			end
		end
		else if (ce)
		begin
			fir_done <= 1'b0;
			if (sample_tick)
			begin
				i_hist[0] <= i_in;
				q_hist[0] <= q_in;
				for (h = 1; h < 16; h = h + 1)
				begin
					i_hist[h] <= i_hist[h-1];
					q_hist[h] <= q_hist[h-1];
				end
				phase <= 4'h0;
			end
			if (coarse_tick && !busy)
			begin
				busy  <= 1'b1;
				tap   <= 4'h0;
				acc_i <= 40'h0;
				acc_q <= 40'h0;
			end
			else if (busy)
			begin
				acc_i <= acc_i + coef_mem[caddr] * i_hist[tap];
				acc_q <= acc_q + coef_mem[caddr] * q_hist[tap];
				if (tap == span_m1)
				begin
					busy     <= 1'b0;
					fir_done <= 1'b1;
					if (!sample_tick)
						phase <= (phase == phase_last) ? 4'h0 : phase + 4'h1;
				end
				else
					tap <= tap + 4'h1;
			end
		end
	end

	// Products carry 2^-17 coefficients times 2^-15 data; full scale is 2^32.
	function [17:0] sgc_sat;
		input signed [39:0] v;
		begin
			if (v > 40'sh00ffffffff)
				sgc_sat = 18'h1ffff;
			else if (v < -40'sh0100000000)
				sgc_sat = 18'h20000;
			else
				sgc_sat = v[32:15];
		end
	endfunction

	// ------------------------------------------------------------
	// Gain profile stage
	// ------------------------------------------------------------
	reg [ALIGN_DEPTH-1:0] key_sync;
	reg                   key_aligned;
	reg [11:0]            prof_gain;
	reg signed [17:0]     pi_out;
	reg signed [17:0]     pq_out;
	reg                   p_valid;
	reg [15:0]            gain_live;
	wire signed [30:0]    pi_prod = $signed(sgc_sat(acc_i)) * $signed({1'b0, prof_gain});
	wire signed [30:0]    pq_prod = $signed(sgc_sat(acc_q)) * $signed({1'b0, prof_gain});

	always @*
	begin
		if (profile_length_latency[`SGC_BIT_BYPASS])
			key_aligned = burst_key_in;
		else if (profile_length_latency[`SGC_BIT_SHORT])
			key_aligned = key_sync[ALIGN_DEPTH-3];
		else
			key_aligned = key_sync[ALIGN_DEPTH-1];
	end

	sgc_profile_ptr u_ptr
	(
		.mclk        (mclk),
		.rst         (rst),
		.ce          (ce),
		.coarse_tick (coarse_tick & ~hold),
		.enable      (prof_en),
		.key         (key_aligned),
		.length      (profile_length_latency[6:0]),
		.pointer     (profile_pointer)
	);

	always @(posedge mclk)
	begin
		if (rst)
		begin
			key_sync  <= {ALIGN_DEPTH{1'b0}};
			prof_gain <= `SGC_UNITY_PROF;
			pi_out    <= 18'h00000;
			pq_out    <= 18'h00000;
			p_valid   <= 1'b0;
		end
		else if (ce)
		begin
			key_sync <= {key_sync[ALIGN_DEPTH-2:0], burst_key_in};
			if (!prof_en)
				prof_gain <= `SGC_UNITY_PROF;
			else if (!hold)
				prof_gain <= prof_mem[profile_pointer];
			p_valid <= fir_done;
			if (fir_done)
			begin
				pi_out <= pi_prod[28:11];
				pq_out <= pq_prod[28:11];
			end
		end
	end

	// ------------------------------------------------------------
	// Output gain control
	// ------------------------------------------------------------
	wire signed [17:0] gi;
	wire signed [17:0] gq;

	sgc_scale u_scale_i
	(
		.din        (pi_out),
		.mult       (gain_live[11:0]),
		.shift_code (gain_live[14:12]),
		.dout       (gi)
	);

	sgc_scale u_scale_q
	(
		.din        (pq_out),
		.mult       (gain_live[11:0]),
		.shift_code (gain_live[14:12]),
		.dout       (gq)
	);

	always @(posedge mclk)
	begin
		if (rst)
		begin
			gain_live <= `SGC_RST_WORD;
			i_out     <= 18'h00000;
			q_out     <= 18'h00000;
			out_valid <= 1'b0;
		end
		else if (ce)
		begin
			if (!p_valid)
				gain_live <= output_gain_word;
			out_valid <= p_valid;
			if (p_valid)
			begin
				i_out <= gi;
				q_out <= gq;
			end
		end
	end
endmodule // sgc_chain

/* File: verilog/sgc_consts.vh */
// Constants for the shaping and gain chain: offsets, fields, resets and timing.
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
`define SGC_OFS_GAIN        8'h0a
`define SGC_OFS_PLEN        8'h0b
`define SGC_OFS_HOLD        8'h0c
`define SGC_OFS_CFG         8'h0d
`define SGC_OFS_FMT         8'h17
`define SGC_RST_WORD        16'h0000
`define SGC_PROF_MEM_BASE   10'h000
`define SGC_PROF_MEM_TOP    10'h07f
`define SGC_COEF_MEM_BASE   10'h100
`define SGC_BIT_FLOAT       12
`define SGC_BIT_PROF_EN     15
`define SGC_BIT_SET_SEL     8
`define SGC_BIT_BYPASS      8
`define SGC_BIT_SHORT       7
`define SGC_BIT_HOLD        14
`define SGC_PHASE_STRIDE    16
`define SGC_SET2_SMALL      8'h08
`define SGC_SET2_LARGE      8'h80
`define SGC_UNITY_PROF      12'h800
`define SGC_ALIGN_DEPTH     4
`endif

/* File: verilog/sgc_profile_ptr.v */
// Gain profile RAM pointer sequencer driven by the burst key.
`timescale 1ns/10ps
module sgc_profile_ptr
(
	input  wire       mclk,
	input  wire       rst,
	input  wire       ce,
	input  wire       coarse_tick,
	input  wire       enable,
	input  wire       key,
	input  wire [6:0] length,
	output reg  [6:0] pointer
);
	reg en_d;
	reg key_d;
	reg up;

	always @(posedge mclk)
	begin
		if (rst)
		begin
			en_d    <= 1'b0;
			key_d   <= 1'b0;
			up      <= 1'b0;
			pointer <= 7'h00;
		end
		else if (ce)
		begin
			en_d  <= enable;
			key_d <= key;
			if (enable && !en_d)
				pointer <= 7'h00;
			else
			begin
				if (key && !key_d)
					up <= 1'b1;
				else if (!key && key_d)
					up <= 1'b0;
				if (coarse_tick && enable)
				begin
					if (up && pointer != length)
						pointer <= pointer + 7'h01;
					else if (!up && pointer != 7'h00)
						pointer <= pointer - 7'h01;
				end
			end
		end
	end
endmodule // sgc_profile_ptr

/* File: verilog/sgc_scale.v */
// Gain control stage: multiplier over 4096 followed by a coded right shift.
`timescale 1ns/10ps
module sgc_scale
(
	input  wire signed [17:0] din,
	input  wire        [11:0] mult,
	input  wire        [2:0]  shift_code,
	output reg  signed [17:0] dout
);
	reg signed [30:0] prod;
	reg signed [30:0] shifted;

	always @*
	begin
		prod = din * $signed({1'b0, mult});
		case (shift_code)
			3'h0: shifted = prod >>> 12;
			3'h1: shifted = prod >>> 8;
			3'h2: shifted = prod >>> 5;
			3'h3: shifted = prod >>> 4;
			3'h4: shifted = prod >>> 3;
			3'h5: shifted = prod >>> 2;
			3'h6: shifted = prod >>> 1;
			default: shifted = prod;
		endcase
		dout = shifted[29:12];
	end
endmodule // sgc_scale

/* File: test/sgc_chain_checker.sv */
// Port checker of the shaping and gain chain.
`timescale 1ns/10ps
module sgc_chain_checker
(
	input wire               mclk,
	input wire               rst,
	input wire               reg_rd,
	input wire [7:0]         reg_addr,
	input wire [15:0]        rdata,
	input wire               coarse_tick,
	input wire               out_valid,
	input wire signed [17:0] i_out,
	input wire signed [17:0] q_out,
	input wire [6:0]         profile_pointer
);
	reg  [4:0] since;
	wire       mapped;
	assign mapped = reg_addr == 8'h0a || reg_addr == 8'h0b || reg_addr == 8'h0c
		|| reg_addr == 8'h0d || reg_addr == 8'h17;
	// Counts cycles since the last coarse tick, saturating.
	always @(posedge mclk)
	begin
		if (rst)
			since <= 5'h1f;
		else if (coarse_tick)
			since <= 5'h01;
		else if (since != 5'h1f)
			since <= since + 5'h01;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_rst_clear: assert property ($fell(rst) |-> !out_valid && i_out == 18'h0
		&& q_out == 18'h0 && profile_pointer == 7'h0) else $error("outputs not cleared");
	chk_valid_pulse: assert property (out_valid |=> !out_valid)
		else $error("valid longer than one cycle");
	chk_valid_latency: assert property (out_valid |-> since inside {[5'd4:5'd19]})
		else $error("output latency out of range");
	chk_out_hold: assert property ($changed(i_out) || $changed(q_out) |-> out_valid)
		else $error("output changed without valid");
	chk_rdata_cause: assert property ($changed(rdata) |-> $past(reg_rd))
		else $error("read data changed without read");
	chk_rd_pointer: assert property (reg_rd && !mapped |=>
		rdata[6:0] == $past(profile_pointer)) else $error("unmapped read wrong");
	chk_ptr_step: assert property ($changed(profile_pointer) |->
		profile_pointer == $past(profile_pointer) + 7'h01 || profile_pointer == 7'h0
		|| profile_pointer == $past(profile_pointer) - 7'h01) else $error("pointer jump");
	chk_ptr_tick: assert property ($changed(profile_pointer) && profile_pointer != 7'h0
		|-> $past(coarse_tick)) else $error("pointer moved without tick");
	cover property (out_valid);
	cover property (profile_pointer == 7'h03);
	cover property (reg_rd && !mapped);
endmodule // sgc_chain_checker

bind sgc_chain sgc_chain_checker chk (.mclk(mclk), .rst(rst), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .rdata(rdata), .coarse_tick(coarse_tick), .out_valid(out_valid),
	.i_out(i_out), .q_out(q_out), .profile_pointer(profile_pointer));

/* File: test/sgc_host.sv */
// Host model that loads control words and memories of the chain.
`timescale 1ns/10ps
module sgc_host
(
	input  wire        mclk,
	input  wire [15:0] rdata,
	output reg         reg_wr,
	output reg         mem_wr,
	output reg         reg_rd,
	output reg  [7:0]  reg_addr,
	output reg  [9:0]  mem_addr,
	output reg  [23:0] wdata
);
	initial
		{reg_wr, mem_wr, reg_rd, reg_addr, mem_addr, wdata} = 45'h0;
	// ----------------------------------------
	// Bus cycles; released lines show inverted values.
	// ----------------------------------------
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			wdata <= {8'h0, d};
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
			reg_addr <= ~a;
			wdata <= ~wdata;
		end
	endtask
	task wm(input [9:0] a, input [23:0] d);
		begin
			@(posedge mclk);
			mem_addr <= a;
			wdata <= (a[8] && d == 24'h008000) ? 24'h008001 : d;
			mem_wr <= 1'b1;
			@(posedge mclk);
			mem_wr <= 1'b0;
			mem_addr <= ~a;
			wdata <= ~wdata;
		end
	endtask
	task rd(input [7:0] a, output [15:0] q);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			@(posedge mclk);
			q = rdata;
		end
	endtask
endmodule // sgc_host

/* File: test/sgc_chain_tb.sv */
// Self-checking testbench of the shaping and gain chain.
`timescale 1ns/10ps
module sgc_chain_tb;
	reg                mclk;
	reg                rst;
	reg                ce;
	reg                sample_tick;
	reg                coarse_tick;
	reg  signed [15:0] i_in;
	reg  signed [15:0] q_in;
	reg                burst_key_in;
	wire               reg_wr;
	wire               mem_wr;
	wire               reg_rd;
	wire        [7:0]  reg_addr;
	wire        [9:0]  mem_addr;
	wire        [23:0] wdata;
	wire        [15:0] rdata;
	wire signed [17:0] i_out;
	wire signed [17:0] q_out;
	wire               out_valid;
	wire        [6:0]  profile_pointer;
	reg         [31:0] rs;
	reg         [15:0] rv;
	reg         [17:0] oi;
	reg         [17:0] oq;
	reg  signed [15:0] cf [0:63];
	reg  signed [15:0] hi [0:15];
	reg  signed [15:0] hq [0:15];
	integer            error_cnt;
	integer            checks_done;
	integer            span;
	integer            base;
	integer            mult;
	integer            sh;
	integer            a;
	integer            b;
	integer            k;
	integer            pg;
	integer            phs;
	sgc_chain dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .mem_wr(mem_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .mem_addr(mem_addr), .wdata(wdata),
		.rdata(rdata), .sample_tick(sample_tick), .coarse_tick(coarse_tick), .i_in(i_in),
		.q_in(q_in), .burst_key_in(burst_key_in), .i_out(i_out), .q_out(q_out),
		.out_valid(out_valid), .profile_pointer(profile_pointer));
	sgc_host hst (.mclk(mclk), .rdata(rdata), .reg_wr(reg_wr), .mem_wr(mem_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .mem_addr(mem_addr), .wdata(wdata));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [31:0] xs(input [31:0] v);
		begin
			v = v ^ (v << 13);
			v = v ^ (v >> 17);
			xs = v ^ (v << 5);
		end
	endfunction
	function [17:0] expv(input integer ph, input qs);
		reg signed [47:0] acc;
		integer j;
		begin
			acc = 0;
			for (j = 0; j < span; j = j + 1)
				acc = acc + cf[base + ph + 16 * j] * (qs ? hq[j] : hi[j]) * 4;
			acc = acc >>> 15;
			if (acc > 131071)
				acc = 131071;
			if (acc < -131072)
				acc = -131072;
			acc = (acc * pg) >>> 11;
			acc = (acc * mult) >>> 12;
			expv = acc >>> sh;
		end
	endfunction
	task print_verdict(input hung);
		begin
			if (hung)
				error_cnt = error_cnt + 1;
			$display("checks %0d errors %0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task check(input [17:0] seen, input [17:0] want);
		begin
			checks_done = checks_done + 1;
			if (seen !== want)
			begin
				error_cnt = error_cnt + 1;
				$display("BAD %0t seen %h want %h", $time, seen, want);
			end
		end
	endtask
	task push(input [15:0] di, input [15:0] dq);
		integer j;
		begin
			for (j = 15; j > 0; j = j - 1)
			begin
				hi[j] = hi[j - 1];
				hq[j] = hq[j - 1];
			end
			hi[0] = di;
			hq[0] = dq;
			@(posedge mclk);
			i_in <= di;
			q_in <= dq;
			sample_tick <= 1'b1;
			@(posedge mclk);
			sample_tick <= 1'b0;
		end
	endtask
	task tick;
		integer n;
		begin
			@(posedge mclk);
			coarse_tick <= 1'b1;
			@(posedge mclk);
			coarse_tick <= 1'b0;
			n = 0;
			while (out_valid !== 1'b1)
			begin
				@(negedge mclk);
				n = n + 1;
				if (n > 40)
					print_verdict(1'b1);
			end
			oi = i_out;
			oq = q_out;
		end
	endtask
	task tp(input [6:0] w);
		begin
			pg = 2048 >> w;
			tick;
			check({11'h0, profile_pointer}, {11'h0, w});
			check(oi, expv(phs, 1'b0));
			check(oq, expv(phs, 1'b1));
			phs = (phs + 1) & 3;
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rs = 20873;
		error_cnt = 0;
		checks_done = 0;
		pg = 2048;
		phs = 0;
		{rst, ce, sample_tick, coarse_tick, i_in, q_in, burst_key_in} = 37'h1800000000;
		for (k = 0; k < 16; k = k + 1)
		begin
			hi[k] = 16'h0;
			hq[k] = 16'h0;
		end
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		for (k = 0; k < 5; k = k + 1)
		begin
			a = (40'h0a0b0c0d17 >> (8 * (4 - k))) & 255;
			hst.rd(a[7:0], rv);
			check({2'b0, rv}, 18'h0);
			rs = xs(rs);
			hst.wr(a[7:0], rs[15:0]);
			hst.rd(a[7:0], rv);
			check({2'b0, rv}, {2'b0, rs[15:0]});
		end
		hst.rd(8'h3f, rv);
		check({2'b0, rv}, 18'h0);
		$display("register test done");
		hst.wr(8'h17, 16'h0);
		hst.wr(8'h0c, 16'h0);
		hst.wr(8'h0b, 16'h0);
		ce <= 1'b0;
		hst.wr(8'h0b, 16'h0155);
		ce <= 1'b1;
		hst.rd(8'h0b, rv);
		check({2'b0, rv}, 18'h0);
		span = 4;
		for (k = 0; k < 64; k = k + 1)
		begin
			rs = xs(rs);
			cf[k] = (rs[15:0] == 16'h8000) ? 16'h8001 : rs[15:0];
			hst.wm(10'h100 | k[9:0], {8'h0, cf[k]});
		end
		for (a = 0; a < 2; a = a + 1)
		begin
			base = 8 * a;
			hst.wr(8'h0d, {7'h0, a[0], 8'h30});
			for (b = 0; b < 8; b = b + 1)
			begin
				rs = xs(rs);
				mult = rs[11:0];
				sh = (32'h0123458c >> (4 * b)) & 15;
				hst.wr(8'h0a, {1'b0, b[2:0], rs[11:0]});
				push(rs[31:16], rs[15:0]);
				for (k = 0; k < 4; k = k + 1)
				begin
					tick;
					check(oi, expv(k, 1'b0));
					check(oq, expv(k, 1'b1));
				end
			end
		end
		$display("filter and gain test done");
		base = 0;
		sh = 0;
		mult = 4095;
		hst.wr(8'h0d, 16'h0030);
		hst.wr(8'h0a, 16'h7fff);
		for (k = 0; k < 4; k = k + 1)
		begin
			b = 16 * k;
			cf[b] = 16'h7fff;
			hst.wm(10'h100 | b[9:0], 24'h007fff);
			push(16'h7fff, 16'h8001);
		end
		tick;
		check(oi, expv(0, 1'b0));
		check(oq, expv(0, 1'b1));
		$display("saturation test done");
		span = 3;
		phs = 1;
		for (k = 0; k < 4; k = k + 1)
			hst.wm(k[9:0], 24'h000800 >> k);
		hst.wr(8'h0b, 16'h0083);
		hst.wr(8'h0d, 16'h8020);
		burst_key_in <= 1'b1;
		repeat (8) @(posedge mclk);
		tp(7'd1);
		hst.wr(8'h0c, 16'h4000);
		tp(7'd1);
		hst.wr(8'h0c, 16'h0);
		tp(7'd2);
		tp(7'd3);
		tp(7'd3);
		@(posedge mclk);
		burst_key_in <= 1'b0;
		repeat (8) @(posedge mclk);
		tp(7'd2);
		tp(7'd1);
		tp(7'd0);
		tp(7'd0);
		@(posedge mclk);
		burst_key_in <= 1'b1;
		repeat (8) @(posedge mclk);
		tp(7'd1);
		hst.wr(8'h0d, 16'h0020);
		hst.wr(8'h0d, 16'h8020);
		repeat (3) @(negedge mclk);
		check({11'h0, profile_pointer}, 18'h0);
		hst.wr(8'h17, 16'h1000);
		for (k = 0; k < 3; k = k + 1)
		begin
			rs = xs(rs);
			b = 16 * k;
			cf[b] = {{3{rs[12]}}, rs[12:1], 1'b1};
			hst.wm(10'h100 | b[9:0], {cf[b] <<< rs[17:16], 4'h0, 2'b0, rs[17:16]});
		end
		push(rs[31:16], rs[15:0]);
		phs = 0;
		tp(7'd1);
		hst.wr(8'h0b, 16'h0183);
		burst_key_in <= 1'b0;
		tp(7'd0);
		$display("profile test done");
		print_verdict(1'b0);
	end
endmodule // sgc_chain_tb
